// ---- hw/mis_alu.sv ----
`timescale 1ns/1ps
`include "mis_map.svh"
// Combinational result and flag generation for one instruction
module mis_alu
	import mis_pkg::*;
(
	input wire mis_op_t op_i,
	input wire logic [7:0] mem_i,
	input wire logic [7:0] work_i,
	input wire logic nib_ovf_i,
	input wire logic ovf_i,
	output logic [7:0] result_o,
	output logic to_mem_o,
	output logic to_work_o,
	output logic upd_null_o,
	output logic upd_ovf_o,
	output logic ovf_o
);
	logic lo_fix;
	logic hi_fix;
	logic [7:0] adj;
	logic [8:0] bcd_sum;

	// Decimal correction choice
	always_comb begin
		lo_fix = (work_i[3:0] > `MIS_BCD_LIMIT) || nib_ovf_i; // [RULE2]
		hi_fix = (work_i[7:4] > `MIS_BCD_LIMIT) || ovf_i; // [RULE3]
		if (lo_fix && hi_fix) begin
			adj = `MIS_ADJ_BOTH; // [RULE4]
		end else if (hi_fix) begin
			adj = `MIS_ADJ_HI;
		end else if (lo_fix) begin
			adj = `MIS_ADJ_LO;
		end else begin
			adj = `MIS_ADJ_NONE;
		end
		bcd_sum = {1'b0, work_i} + {1'b0, adj};
	end

	// Result and destination per operation
	always_comb begin
		result_o = `MIS_ZERO;
		to_mem_o = 1'b0;
		to_work_o = 1'b0;
		upd_null_o = 1'b0;
		upd_ovf_o = 1'b0;
		ovf_o = ovf_i;
		case (op_i)
			MIS_OP_INV_W: begin
				result_o = ~mem_i; // [RULE1]
				to_work_o = 1'b1;
				upd_null_o = 1'b1;
			end
			MIS_OP_BCD: begin
				result_o = bcd_sum[7:0]; // [RULE4]
				to_mem_o = 1'b1;
				upd_ovf_o = 1'b1; // [RULE5]
				ovf_o = bcd_sum[8] | hi_fix;
			end
			MIS_OP_SUB_M: begin
				result_o = mem_i - `MIS_ONE; // [RULE6]
				to_mem_o = 1'b1;
				upd_null_o = 1'b1;
			end
			MIS_OP_SUB_W: begin
				result_o = mem_i - `MIS_ONE; // [RULE7]
				to_work_o = 1'b1;
				upd_null_o = 1'b1;
			end
			MIS_OP_ADD_M: begin
				result_o = mem_i + `MIS_ONE; // [RULE8]
				to_mem_o = 1'b1;
				upd_null_o = 1'b1;
			end
			MIS_OP_ADD_W: begin
				result_o = mem_i + `MIS_ONE; // [RULE9]
				to_work_o = 1'b1;
				upd_null_o = 1'b1;
			end
			default: begin
				result_o = `MIS_ZERO;
			end
		endcase
	end
endmodule // mis_alu

// ---- hw/mis_core.sv ----
`timescale 1ns/1ps
`include "mis_map.svh"
// Operation
// [RULE1] Inverting into the working register loads it with the complemented memory byte.
// [RULE2] Decimal adjust adds 6 to the low nibble when above 9 or the nibble carry is set.
// [RULE3] Decimal adjust adds 6 to the high nibble when above 9 or the carry is set.
// [RULE4] Decimal adjust adds 00, 06, 60 or 66 hex and writes the sum to memory.
// [RULE5] Decimal adjust touches only the carry, set when the decimal sum reaches 100.
// [RULE6] Memory decrement writes the byte minus one back and updates the zero flag.
// [RULE7] Working decrement puts the byte minus one in the working register only.
// [RULE8] Memory increment writes the byte plus one back and updates the zero flag.
// [RULE9] Working increment puts the byte plus one in the working register only.
// [RULE10] Power-down stops execution and gates the clock, keeping all state.
// [RULE11] Power-down clears the watchdog counter and its prescaler.
// [RULE12] Power-down sets the sleep flag and clears the expiry flag, nothing else; an expiry in the same cycle leaves the expiry flag set instead.
// [RULE13] Goto loads the program counter with the instruction address.
// [RULE14] Goto takes two cycles with one dummy slot.
// [RULE15] An updated zero flag is set exactly when the 8-bit result is zero.
module mis_core
	import mis_pkg::*;
#(
	parameter int PC_W = 11,
	parameter int WDT_W = 16,
	parameter int PRE_W = 8
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic clk_en_i,
	input wire logic op_valid_i,
	input wire mis_op_t op_i,
	input wire logic [PC_W-1:0] goto_addr_i,
	input wire logic [7:0] mem_rdata_i,
	input wire logic wake_i,
	output logic op_ready_o,
	output logic [7:0] mem_wdata_o,
	output logic mem_we_o,
	output logic [7:0] working_register_o,
	output logic null_result_flag_o,
	output logic overflow_flag_o,
	output logic nibble_overflow_flag_o,
	input wire logic nibble_overflow_flag_i,
	input wire logic nib_set_i,
	output logic sleep_flag_o,
	output logic expiry_flag_o,
	input wire logic wdt_expire_i,
	output logic [PC_W-1:0] pc_o,
	output logic fetch_dummy_o,
	output logic clk_gate_o,
	output logic [WDT_W-1:0] watchdog_counter_o,
	output logic [PRE_W-1:0] prescaler_o
);
	// Refuse widths the sequencer cannot serve
	if (PC_W < 1 || PC_W > 16 || WDT_W < 1 || PRE_W < 1) begin : g_bad_width
		$error("mis_core: unsupported width");
	end

	mis_state_t state_q, state_d;
	logic [7:0] work_q, work_d;
	logic [7:0] mem_wdata_q, mem_wdata_d;
	logic mem_we_q, mem_we_d;
	logic null_q, null_d, ovf_q, ovf_d, sleep_q, sleep_d, exp_q, exp_d;
	logic [PC_W-1:0] pc_q, pc_d;
	logic [WDT_W-1:0] wdt_q, wdt_d;
	logic [PRE_W-1:0] pre_q, pre_d;
	logic wake_s1_q, wake_s2_q;
	logic [7:0] alu_res;
	logic to_mem, to_work, upd_null, upd_ovf, alu_ovf, take;

	// Result computation
	mis_alu u_alu (
		.op_i(op_i),
		.mem_i(mem_rdata_i),
		.work_i(work_q),
		.nib_ovf_i(nibble_overflow_flag_i),
		.ovf_i(ovf_q),
		.result_o(alu_res),
		.to_mem_o(to_mem),
		.to_work_o(to_work),
		.upd_null_o(upd_null),
		.upd_ovf_o(upd_ovf),
		.ovf_o(alu_ovf)
	);

	assign take = op_valid_i && (state_q == MIS_ST_RUN);
	assign op_ready_o = (state_q == MIS_ST_RUN);
	assign fetch_dummy_o = (state_q == MIS_ST_DUMMY);
	assign clk_gate_o = (state_q == MIS_ST_SLEEP); // [RULE10]
	assign nibble_overflow_flag_o = nibble_overflow_flag_i | nib_set_i;

	// Next state of sequencer, registers and flags
	always_comb begin
		state_d = state_q;
		work_d = work_q;
		mem_wdata_d = mem_wdata_q;
		mem_we_d = 1'b0;
		null_d = null_q;
		ovf_d = ovf_q;
		sleep_d = sleep_q;
		exp_d = exp_q | wdt_expire_i;
		pc_d = pc_q;
		pre_d = pre_q + 1'b1;
		wdt_d = (pre_q == {PRE_W{1'b1}}) ? wdt_q + 1'b1 : wdt_q;
		case (state_q)
			MIS_ST_RUN: begin
				if (take) begin
					pc_d = pc_q + 1'b1;
					if (to_work) begin
						work_d = alu_res;
					end
					if (to_mem) begin
						mem_wdata_d = alu_res;
						mem_we_d = 1'b1;
					end
					if (upd_null) begin
						null_d = (alu_res == `MIS_ZERO); // [RULE15]
					end
					if (upd_ovf) begin
						ovf_d = alu_ovf; // [RULE5]
					end
					if (op_i == MIS_OP_GOTO) begin
						pc_d = goto_addr_i; // [RULE13]
						state_d = MIS_ST_DUMMY; // [RULE14]
					end
					if (op_i == MIS_OP_SLEEP) begin
						wdt_d = '0; // [RULE11]
						pre_d = '0;
						sleep_d = 1'b1; // [RULE12]
						exp_d = wdt_expire_i; // Expiry in the same cycle wins over the clear
						state_d = MIS_ST_SLEEP; // [RULE10]
					end
				end
			end
			MIS_ST_DUMMY: begin
				state_d = MIS_ST_RUN; // [RULE14]
			end
			MIS_ST_SLEEP: begin
				wdt_d = wdt_q; // [RULE10]
				pre_d = pre_q;
				exp_d = exp_q;
				if (wake_s2_q) begin
					state_d = MIS_ST_RUN;
				end
			end
			default: begin
				state_d = MIS_ST_RUN;
			end
		endcase
	end

	// Registers
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= MIS_ST_RUN;
			work_q <= `MIS_ZERO;
			mem_wdata_q <= `MIS_ZERO;
			mem_we_q <= 1'b0;
			null_q <= 1'b0;
			ovf_q <= 1'b0;
			sleep_q <= 1'b0;
			exp_q <= 1'b0;
			pc_q <= '0;
			wdt_q <= '0;
			pre_q <= '0;
			wake_s1_q <= 1'b0;
			wake_s2_q <= 1'b0;
		end else if (clk_en_i) begin
			state_q <= state_d;
			work_q <= work_d;
			mem_wdata_q <= mem_wdata_d;
			mem_we_q <= mem_we_d;
			null_q <= null_d;
			ovf_q <= ovf_d;
			sleep_q <= sleep_d;
			exp_q <= exp_d;
			pc_q <= pc_d;
			wdt_q <= wdt_d;
			pre_q <= pre_d;
			wake_s1_q <= wake_i;
			wake_s2_q <= wake_s1_q;
		end
	end

	assign mem_wdata_o = mem_wdata_q;
	assign mem_we_o = mem_we_q;
	assign working_register_o = work_q;
	assign null_result_flag_o = null_q;
	assign overflow_flag_o = ovf_q;
	assign sleep_flag_o = sleep_q;
	assign expiry_flag_o = exp_q;
	assign pc_o = pc_q;
	assign watchdog_counter_o = wdt_q;
	assign prescaler_o = pre_q;

	// Checks
	inv_to_work_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE1]
		take && clk_en_i && op_i == MIS_OP_INV_W |=> work_q == ~$past(mem_rdata_i) && !mem_we_q)
		else $error("invert result wrong");
	bcd_write_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE4]
		take && clk_en_i && op_i == MIS_OP_BCD |=> mem_we_q && null_q == $past(null_q))
		else $error("bcd adjust write wrong");
	dec_mem_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE6]
		take && clk_en_i && op_i == MIS_OP_SUB_M |=> mem_wdata_q == $past(mem_rdata_i) - `MIS_ONE)
		else $error("decrement wrong");
	dec_work_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE7]
		take && clk_en_i && op_i == MIS_OP_SUB_W |=> work_q == $past(mem_rdata_i) - `MIS_ONE)
		else $error("working decrement wrong");
	inc_mem_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE8]
		take && clk_en_i && op_i == MIS_OP_ADD_M |=>
		mem_we_q && mem_wdata_q == $past(mem_rdata_i) + `MIS_ONE)
		else $error("increment wrong");
	inc_work_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE9]
		take && clk_en_i && op_i == MIS_OP_ADD_W |=> work_q == $past(mem_rdata_i) + `MIS_ONE)
		else $error("working increment wrong");
	sleep_entry_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE12]
		take && clk_en_i && op_i == MIS_OP_SLEEP |=>
		sleep_q && exp_q == $past(wdt_expire_i) && wdt_q == '0 && pre_q == '0 && clk_gate_o)
		else $error("power down entry wrong");
	goto_two_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE14]
		take && clk_en_i && op_i == MIS_OP_GOTO |=> fetch_dummy_o && pc_q == $past(goto_addr_i))
		else $error("goto sequence wrong");
	null_flag_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE15]
		take && clk_en_i && upd_null |=> null_q == ($past(alu_res) == `MIS_ZERO))
		else $error("zero flag wrong");
endmodule // mis_core

// ---- hw/mis_map.svh ----
`ifndef MIS_MAP_SVH
`define MIS_MAP_SVH
`define MIS_BCD_LIMIT 4'h9
`define MIS_BCD_FIX 4'h6
`define MIS_ADJ_NONE 8'h00
`define MIS_ADJ_LO 8'h06
`define MIS_ADJ_HI 8'h60
`define MIS_ADJ_BOTH 8'h66
`define MIS_ONE 8'h01
`define MIS_ZERO 8'h00
`endif

// ---- hw/mis_pkg.sv ----
package mis_pkg;
	typedef enum logic [3:0] {
		MIS_OP_NONE = 4'h0,
		MIS_OP_INV_W = 4'h1,
		MIS_OP_BCD = 4'h2,
		MIS_OP_SUB_M = 4'h3,
		MIS_OP_SUB_W = 4'h4,
		MIS_OP_ADD_M = 4'h5,
		MIS_OP_ADD_W = 4'h6,
		MIS_OP_SLEEP = 4'h7,
		MIS_OP_GOTO = 4'h8
	} mis_op_t;
	typedef enum logic [1:0] {
		MIS_ST_RUN = 2'b00,
		MIS_ST_DUMMY = 2'b01,
		MIS_ST_SLEEP = 2'b10
	} mis_state_t;
endpackage

// ---- tb/mcu_instruction_semantics_tb_top.sv ----
`timescale 1ns/1ps
// Instruction stream against a reference model
module mcu_instruction_semantics_tb_top;
	import mis_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic vld = 1'b0;
	logic nib = 1'b0;
	logic wake = 1'b0;
	logic wdt = 1'b0;
	logic ce = 1'b1;
	logic ns = 1'b0;
	logic no;
	logic [7:0] pre_s;
	mis_op_t cop [8] = '{MIS_OP_ADD_M, MIS_OP_SUB_W, MIS_OP_INV_W, MIS_OP_ADD_W,
		MIS_OP_INV_W, MIS_OP_BCD, MIS_OP_INV_W, MIS_OP_BCD};
	logic [3:0] cad [8] = '{4'hf, 4'hf, 4'h0, 4'hf, 4'h6, 4'h1, 4'h5, 4'h2};
	mis_op_t op = MIS_OP_NONE;
	logic [10:0] ga = '0;
	logic [3:0] addr = '0;
	logic [7:0] rd, wd, w_o, ew, pre;
	logic [7:0] em [16];
	logic [10:0] pc_o, epc;
	logic [15:0] wdc;
	logic we_o, rdy, z_o, c_o, sl_o, ex_o, dum, gate, ez, ec;
	logic [31:0] rnd = 32'h9fb99d8b;
	int miscompares = 0;
	int n_tests = 0;
	int cyc = 0;

	mis_core u_mis_core (
		.clk_sys_i(clk), .rst_n_i(rst_n), .clk_en_i(ce), .op_valid_i(vld), .op_i(op),
		.goto_addr_i(ga), .mem_rdata_i(rd), .wake_i(wake), .op_ready_o(rdy),
		.mem_wdata_o(wd), .mem_we_o(we_o), .working_register_o(w_o),
		.null_result_flag_o(z_o), .overflow_flag_o(c_o), .nibble_overflow_flag_o(no),
		.nibble_overflow_flag_i(nib), .nib_set_i(ns), .sleep_flag_o(sl_o),
		.expiry_flag_o(ex_o), .wdt_expire_i(wdt), .pc_o(pc_o), .fetch_dummy_o(dum),
		.clk_gate_o(gate), .watchdog_counter_o(wdc), .prescaler_o(pre)
	);
	mis_mem_model u_mis_mem_model (
		.clk_i(clk), .addr_i(addr), .we_i(we_o), .wdata_i(wd), .rdata_o(rd)
	);

	// Clock and hang guard
	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			summarize();
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	// Expected {overflow, result} of one op
	function automatic logic [8:0] calc(mis_op_t o, logic [7:0] m, w, logic n, c);
		logic lo, hi;
		logic [8:0] s;
		lo = w[3:0] > 4'h9 || n;
		hi = w[7:4] > 4'h9 || c;
		s = {1'b0, w} + {1'b0, hi ? 4'h6 : 4'h0, lo ? 4'h6 : 4'h0};
		case (o)
			MIS_OP_INV_W: calc = {c, ~m};
			MIS_OP_SUB_M, MIS_OP_SUB_W: calc = {c, m - 8'h01};
			MIS_OP_BCD: calc = {s[8] | hi, s[7:0]};
			default: calc = {c, m + 8'h01};
		endcase
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Present one op, check its results one cycle later
	task automatic run(input mis_op_t o, input logic [3:0] a, input logic n);
		logic [8:0] r;
		logic we;
		r = calc(o, em[a], ew, n, ec);
		we = o inside {MIS_OP_BCD, MIS_OP_SUB_M, MIS_OP_ADD_M};
		op = o;
		addr = a;
		nib = n;
		vld = 1'b1;
		@(negedge clk);
		epc++;
		ec = r[8];
		if (o != MIS_OP_BCD) ez = r[7:0] == 8'h00;
		if (we) em[a] = r[7:0];
		else ew = r[7:0];
		chk(we_o, we);
		chk(we ? wd : w_o, r[7:0]);
		chk({w_o, z_o, c_o, pc_o}, {ew, ez, ec, epc});
		chk(no, n | ns);
	endtask

	task automatic rand_ops(input int n);
		repeat (n) begin
			rnd = lfsr(rnd);
			ns = rnd[13];
			run(mis_op_t'(4'(rnd[7:0] % 6 + 1)), rnd[11:8], rnd[12]);
		end
	endtask

	task automatic summarize;
		if (miscompares == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		for (int i = 0; i < 16; i++) em[i] = 8'(i * 17);
		{ew, ez, ec, epc} = '0;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		// Wrap corners and both nibble corrections
		foreach (cop[i]) run(cop[i], cad[i], 1'b1);
		rand_ops(300);
		vld = 1'b0;
		wdt = 1'b1;
		@(negedge clk);
		wdt = 1'b0;
		@(negedge clk);
		chk(ex_o, 1'b1);
		// Power-down keeps state, clears the watchdog
		op = MIS_OP_SLEEP;
		vld = 1'b1;
		@(negedge clk);
		vld = 1'b0;
		chk({sl_o, ex_o, gate, rdy}, 4'b1010);
		chk({wdc, pre}, 24'h0);
		chk({w_o, z_o, c_o}, {ew, ez, ec});
		repeat (20) @(negedge clk);
		chk({gate, rdy}, 2'b10);
		chk({wdc, pre}, 24'h0);
		wake = 1'b1;
		for (int i = 0; i < 10 && rdy !== 1'b1; i++) @(negedge clk);
		wake = 1'b0;
		chk(rdy, 1'b1);
		// Jump with an op refused in the dummy slot
		rnd = lfsr(rnd);
		ga = rnd[10:0];
		op = MIS_OP_GOTO;
		vld = 1'b1;
		@(negedge clk);
		epc = ga;
		chk({pc_o, dum, rdy}, {epc, 2'b10});
		op = MIS_OP_ADD_W;
		@(negedge clk);
		vld = 1'b0;
		chk({rdy, w_o, pc_o}, {1'b1, ew, epc});
		@(negedge clk);
		// Enable low freezes all state and refuses the op on offer
		pre_s = pre;
		ce = 1'b0;
		op = MIS_OP_ADD_W;
		vld = 1'b1;
		repeat (3) @(negedge clk);
		chk({w_o, pc_o, pre, we_o}, {ew, epc, pre_s, 1'b0});
		vld = 1'b0;
		ce = 1'b1;
		@(negedge clk);
		rand_ops(50);
		summarize();
	end
endmodule // mcu_instruction_semantics_tb_top

// ---- tb/mis_mem_model.sv ----
`timescale 1ns/1ps
// Data memory beside the core; writes land at the taken op's address
module mis_mem_model (
	input wire logic clk_i,
	input wire logic [3:0] addr_i,
	input wire logic we_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o
);
	logic [7:0] mem [16];
	logic [3:0] addr_q;
	// Fill with 00, 11 .. ff so both wrap corners exist
	initial for (int i = 0; i < 16; i++) mem[i] = 8'(i * 17);
	// Latch the address each edge, write one cycle after the take
	always @(posedge clk_i) begin
		if (we_i) mem[addr_q] <= wdata_i;
		addr_q <= addr_i;
	end
	// Forward a pending write so back-to-back ops see fresh data
	assign rdata_o = (we_i && addr_q == addr_i) ? wdata_i : mem[addr_i];
endmodule // mis_mem_model
